// *** logic/mbfr_framer.sv ***
`timescale 1ns/1ps
module mbfr_framer #(
  parameter int FIFO_DEPTH = mbfr_pkg::MBFR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tcp_mode,
  input wire logic [15:0] rx_port,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  output logic rx_ready,
  output logic [7:0] req_data,
  output logic req_valid,
  output logic req_last,
  output logic req_err,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  output logic rsp_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready
);
  import mbfr_pkg::*;

  // ==========================================================
  // crc step
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ MBFR_CHECKSUM_POLYNOMIAL) : (r >> 1);
    end
    return r;
  endfunction

  // ==========================================================
  // receive side
  typedef enum logic [1:0] {MBFR_RX_HDR, MBFR_RX_BODY, MBFR_RX_DROP} mbfr_rx_e;
  mbfr_rx_e rx_st_reg;
  logic [2:0] rx_idx_reg;
  logic [7:0] rx_left_reg;
  logic [15:0] tid_reg;
  logic [15:0] rx_crc_reg;
  logic [7:0] hold_reg [2];
  logic [1:0] hold_cnt_reg;
  logic f_in_valid;
  logic f_in_ready;
  logic [7:0] f_in_data;
  logic f_in_last;
  logic f_in_err;
  logic [9:0] f_out_data;
  logic f_out_valid;
  logic rx_take;
  logic ser_end;
  logic hdr_bad;

  assign rx_take = rx_valid && rx_ready;
  assign rx_ready = f_in_ready;
  assign ser_end = rx_take && rx_last && !tcp_mode;
  // header byte is wrong for the given index, or rx_port is not MBFR_TCP_PORT
  assign hdr_bad = (rx_port != MBFR_TCP_PORT) ||
                   ((rx_idx_reg == 3'd2 || rx_idx_reg == 3'd3) &&
                    rx_data != MBFR_PROTO_ID) ||
                   (rx_idx_reg == 3'd4 && rx_data != MBFR_LEN_HI);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_reg <= MBFR_RX_HDR;
      rx_idx_reg <= '0;
      rx_left_reg <= '0;
      tid_reg <= '0;
    end else if (rx_take && tcp_mode) begin
      case (rx_st_reg)
        MBFR_RX_HDR: begin
          if (rx_idx_reg == 3'd0) tid_reg[15:8] <= rx_data;
          if (rx_idx_reg == 3'd1) tid_reg[7:0] <= rx_data;
          if (hdr_bad) begin
            rx_st_reg <= rx_last ? MBFR_RX_HDR : MBFR_RX_DROP;
            rx_idx_reg <= '0;
          end else if (rx_idx_reg == 3'(MBFR_HDR_LEN - 1)) begin
            rx_left_reg <= rx_data;
            rx_idx_reg <= '0;
            rx_st_reg <= (rx_data == 8'h00) ? MBFR_RX_HDR : MBFR_RX_BODY;
          end else begin
            rx_idx_reg <= rx_idx_reg + 3'd1;
          end
        end
        MBFR_RX_BODY: begin
          rx_left_reg <= rx_left_reg - 8'h01;
          if (rx_left_reg == 8'h01) rx_st_reg <= MBFR_RX_HDR;
        end
        MBFR_RX_DROP: begin
          if (rx_last) rx_st_reg <= MBFR_RX_HDR;
        end
        default: rx_st_reg <= MBFR_RX_HDR;
      endcase
    end
  end

  // serial crc check with two-byte delay so the crc tail is never forwarded
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_crc_reg <= MBFR_CRC_INIT;
      hold_cnt_reg <= '0;
      hold_reg[0] <= '0;
      hold_reg[1] <= '0;
    end else if (rx_take && !tcp_mode) begin
      hold_reg[0] <= rx_data;
      hold_reg[1] <= hold_reg[0];
      if (rx_last) begin
        hold_cnt_reg <= '0;
        rx_crc_reg <= MBFR_CRC_INIT;
      end else begin
        if (hold_cnt_reg != 2'd2) hold_cnt_reg <= hold_cnt_reg + 2'd1;
        if (hold_cnt_reg == 2'd2) rx_crc_reg <= crc_byte(rx_crc_reg,
                                                         hold_reg[1]);
      end
    end
  end

  // fifo input mux: tcp bodies pass directly, serial bytes are delayed
  always_comb begin
    f_in_valid = 1'b0;
    f_in_data = rx_data;
    f_in_last = 1'b0;
    f_in_err = 1'b0;
    if (rx_valid && tcp_mode && rx_st_reg == MBFR_RX_BODY) begin
      f_in_valid = 1'b1;
      f_in_last = rx_left_reg == 8'h01;
    end else if (rx_valid && !tcp_mode && hold_cnt_reg == 2'd2) begin
      f_in_data = hold_reg[1];
      f_in_valid = !rx_last;
    end else if (rx_valid && !tcp_mode && rx_last) begin
      f_in_valid = 1'b1;
      f_in_data = hold_reg[1];
      f_in_last = 1'b1;
      f_in_err = 1'b1;
    end
    if (rx_valid && !tcp_mode && rx_last && hold_cnt_reg == 2'd2) begin
      // first crc byte is the low register byte
      f_in_valid = 1'b1;
      f_in_last = 1'b1;
      f_in_err = crc_byte(rx_crc_reg, hold_reg[1]) !=
                 {rx_data, hold_reg[0]};
    end
  end

  mbfr_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_data({f_in_err, f_in_last, f_in_data}),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .out_data(f_out_data),
    .out_valid(f_out_valid),
    .out_ready(!req_valid || 1'b1)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_valid <= 1'b0;
      req_data <= '0;
      req_last <= 1'b0;
      req_err <= 1'b0;
    end else begin
      req_valid <= f_out_valid;
      req_data <= f_out_data[7:0];
      req_last <= f_out_valid && f_out_data[8];
      req_err <= f_out_valid && f_out_data[9];
    end
  end

  // ==========================================================
  // transmit side
  typedef enum logic [2:0] {
    MBFR_TX_IDLE, MBFR_TX_HDR, MBFR_TX_BODY, MBFR_TX_CRC0, MBFR_TX_CRC1
  } mbfr_tx_e;
  mbfr_tx_e tx_st_reg;
  logic [7:0] buf_reg [256];
  logic [7:0] cnt_reg;
  logic [7:0] pos_reg;
  logic [2:0] hidx_reg;
  logic [15:0] tx_crc_reg;
  logic collecting_reg;
  logic tx_adv;

  assign rsp_ready = collecting_reg;
  assign tx_adv = !tx_valid || tx_ready;

  always_ff @(posedge clk) begin
    if (rsp_valid && collecting_reg) buf_reg[cnt_reg] <= rsp_data;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_reg <= MBFR_TX_IDLE;
      collecting_reg <= 1'b1;
      cnt_reg <= '0;
      pos_reg <= '0;
      hidx_reg <= '0;
      tx_crc_reg <= MBFR_CRC_INIT;
      tx_valid <= 1'b0;
      tx_data <= '0;
      tx_last <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) tx_valid <= 1'b0;
      case (tx_st_reg)
        MBFR_TX_IDLE: begin
          if (rsp_valid && collecting_reg) begin
            cnt_reg <= cnt_reg + 8'h01;
            if (rsp_last) begin
              collecting_reg <= 1'b0;
              pos_reg <= '0;
              hidx_reg <= '0;
              tx_crc_reg <= MBFR_CRC_INIT;
              tx_st_reg <= tcp_mode ? MBFR_TX_HDR : MBFR_TX_BODY;
            end
          end
        end
        MBFR_TX_HDR: if (tx_adv) begin
          tx_valid <= 1'b1;
          tx_last <= 1'b0;
          case (hidx_reg)
            3'd0: tx_data <= tid_reg[15:8];
            3'd1: tx_data <= tid_reg[7:0];
            3'd4: tx_data <= MBFR_LEN_HI;
            3'd5: tx_data <= cnt_reg;
            default: tx_data <= MBFR_PROTO_ID;
          endcase
          hidx_reg <= hidx_reg + 3'd1;
          if (hidx_reg == 3'(MBFR_HDR_LEN - 1)) tx_st_reg <= MBFR_TX_BODY;
        end
        MBFR_TX_BODY: if (tx_adv) begin
          tx_valid <= 1'b1;
          tx_data <= buf_reg[pos_reg];
          tx_crc_reg <= crc_byte(tx_crc_reg, buf_reg[pos_reg]);
          pos_reg <= pos_reg + 8'h01;
          tx_last <= tcp_mode && pos_reg + 8'h01 == cnt_reg;
          if (pos_reg + 8'h01 == cnt_reg) begin
            tx_st_reg <= tcp_mode ? MBFR_TX_IDLE : MBFR_TX_CRC0;
            if (tcp_mode) begin
              collecting_reg <= 1'b1;
              cnt_reg <= '0;
            end
          end
        end
        MBFR_TX_CRC0: if (tx_adv) begin
          tx_valid <= 1'b1;
          tx_data <= tx_crc_reg[7:0];
          tx_st_reg <= MBFR_TX_CRC1;
        end
        MBFR_TX_CRC1: if (tx_adv) begin
          tx_valid <= 1'b1;
          tx_data <= tx_crc_reg[15:8];
          tx_last <= 1'b1;
          tx_st_reg <= MBFR_TX_IDLE;
          collecting_reg <= 1'b1;
          cnt_reg <= '0;
        end
        default: tx_st_reg <= MBFR_TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // checks
  chk_crc_reset: assert property (@(posedge clk) disable iff (!arst_n)
    $past(rsp_valid && rsp_last && rsp_ready && tx_st_reg == MBFR_TX_IDLE)
    |-> tx_crc_reg == MBFR_CRC_INIT) else $error("crc reset");
  chk_len_high_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (tx_st_reg == MBFR_TX_HDR && hidx_reg == 3'd4 && tx_adv)
    |=> tx_data == MBFR_LEN_HI) else $error("length high nonzero");
  chk_len_low: assert property (@(posedge clk) disable iff (!arst_n)
    (tx_st_reg == MBFR_TX_HDR && hidx_reg == 3'd5 && tx_adv)
    |=> tx_data == cnt_reg && tx_valid) else $error("bad length");
  chk_tid_copy: assert property (@(posedge clk) disable iff (!arst_n)
    (tx_st_reg == MBFR_TX_HDR && hidx_reg == 3'd0 && tx_adv)
    |=> tx_data == tid_reg[15:8]) else $error("tid not copied");
  chk_no_tcp_crc: assert property (@(posedge clk) disable iff (!arst_n)
    tcp_mode && tx_st_reg == MBFR_TX_IDLE |-> ##1
    tx_st_reg != MBFR_TX_CRC0) else $error("crc in tcp");
  chk_hdr_six: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(tx_st_reg == MBFR_TX_BODY) && tcp_mode
    |-> $past(hidx_reg) == 3'd5) else $error("header not six");
  chk_port_gate: assert property (@(posedge clk) disable iff (!arst_n)
    rx_take && tcp_mode && rx_st_reg == MBFR_RX_HDR &&
    rx_port != MBFR_TCP_PORT |=> rx_st_reg != MBFR_RX_BODY)
    else $error("wrong port accepted");
  chk_body_end: assert property (@(posedge clk) disable iff (!arst_n)
    rx_take && tcp_mode && rx_st_reg == MBFR_RX_BODY && rx_left_reg == 8'h01
    |=> rx_st_reg == MBFR_RX_HDR) else $error("body length");
  chk_serial_crc_last: assert property (@(posedge clk) disable iff (!arst_n)
    tx_st_reg == MBFR_TX_CRC1 && tx_adv |=> tx_last && tx_valid)
    else $error("crc tail");
  chk_body_pass: assert property (@(posedge clk) disable iff (!arst_n)
    f_in_valid && tcp_mode && rx_st_reg == MBFR_RX_BODY |->
    f_in_data == rx_data) else $error("body altered");
endmodule

// *** logic/mbfr_pkg.sv ***
package mbfr_pkg;
  // ==========================================================
  // framing constants
  localparam logic [15:0] MBFR_TCP_PORT = 16'h01F6;
  localparam int MBFR_HDR_LEN = 6;
  localparam logic [15:0] MBFR_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] MBFR_CHECKSUM_POLYNOMIAL = 16'hA001;
  localparam logic [7:0] MBFR_PROTO_ID = 8'h00;
  localparam logic [7:0] MBFR_LEN_HI = 8'h00;
  localparam int MBFR_FIFO_DEPTH = 32;
  localparam int MBFR_DATA_W = 8;
endpackage

// *** logic/mbfr_fifo.sv ***
`timescale 1ns/1ps
module mbfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// *** dv/mbfr_client.sv ***
`timescale 1ns/1ps
module mbfr_client (
  input wire logic clk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_ready_en,
  output logic tx_ready
);
  logic [7:0] got_q[$];
  logic lst_q[$];
  logic [7:0] prev;
  int stall_every = 0;
  int cyc = 0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end
  // ==========
  // request side: whole frames, each byte held until taken
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      rx_data <= b[i];
      rx_valid <= 1'b1;
      rx_last <= (i == b.size() - 1);
      prev = b[i];
      @(posedge clk iff rx_ready === 1'b1);
    end
  endtask
  // released data line shows the inverse of the last byte
  task automatic idle();
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~prev;
  endtask
  // ==========
  // response side: no checksum expected in tcp mode, stalls on demand
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_data);
      lst_q.push_back(tx_last);
    end
    tx_ready <= tx_ready_en && (stall_every == 0 || cyc % stall_every != 0);
  end
endmodule

// *** dv/modbus_tcp_frame_prefix_and_crc_bench.sv ***
`timescale 1ns/1ps
module modbus_tcp_frame_prefix_and_crc_bench;
  import mbfr_pkg::*;
  typedef logic [7:0] mbfr_bytes_t[$];
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic tcp_mode = 1'b1;
  logic [15:0] rx_port = MBFR_TCP_PORT;
  logic [7:0] rsp_data = 8'h00;
  logic rsp_valid = 1'b0;
  logic rsp_last = 1'b0;
  logic [7:0] rx_data, req_data, tx_data;
  logic rx_valid, rx_last, rx_ready, req_valid, req_last, req_err;
  logic rsp_ready, tx_valid, tx_last, tx_ready;
  int num_errors = 0;
  int checks_done = 0;
  mbfr_bytes_t req_q;
  logic lst_q[$];
  logic err_q[$];
  always #20 clk = ~clk;
  mbfr_framer #(.FIFO_DEPTH(32)) dut (.clk(clk), .arst_n(arst_n),
    .tcp_mode(tcp_mode), .rx_port(rx_port), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
    .req_data(req_data), .req_valid(req_valid), .req_last(req_last),
    .req_err(req_err), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .rsp_last(rsp_last), .rsp_ready(rsp_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
  mbfr_client client (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready_en(arst_n),
    .tx_ready(tx_ready));
  always @(posedge clk) begin
    if (req_valid === 1'b1) begin
      req_q.push_back(req_data);
      lst_q.push_back(req_last);
      err_q.push_back(req_err);
    end
  end
  // ==========
  // helpers
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask
  function automatic logic [15:0] crc16(input mbfr_bytes_t b);
    logic [15:0] c;
    c = MBFR_CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ MBFR_CHECKSUM_POLYNOMIAL) : (c >> 1);
      end
    end
    return c;
  endfunction
  task automatic wait_n(input int n, input logic on_tx);
    int k;
    k = 0;
    while ((on_tx ? client.got_q.size() : req_q.size()) < n && k < 300) begin
      @(posedge clk);
      k++;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic check_req(input mbfr_bytes_t exp, input int flen);
    check8(8'(req_q.size()), 8'(exp.size()));
    foreach (exp[i]) begin
      check8(req_q[i], exp[i]);
      check1(lst_q[i], 1'((i % flen) == flen - 1));
    end
    req_q.delete();
    lst_q.delete();
  endtask
  task automatic check_tx(input mbfr_bytes_t exp);
    check8(8'(client.got_q.size()), 8'(exp.size()));
    foreach (exp[i]) begin
      check8(client.got_q[i], exp[i]);
      check1(client.lst_q[i], 1'(i == exp.size() - 1));
    end
    client.got_q.delete();
    client.lst_q.delete();
  endtask
  task automatic rsp_send(input mbfr_bytes_t b);
    for (int i = 0; i < b.size(); i++) begin
      rsp_data <= b[i];
      rsp_valid <= 1'b1;
      rsp_last <= (i == b.size() - 1);
      @(posedge clk iff rsp_ready === 1'b1);
    end
    rsp_valid <= 1'b0;
    rsp_last <= 1'b0;
    rsp_data <= ~b[b.size() - 1];
  endtask
  // ==========
  // scenarios
  task automatic t_tcp_req();
    client.send('{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h06,
      8'h09, 8'h03, 8'h00, 8'h04, 8'h00, 8'h01});
    client.send('{8'h03, 8'h29, 8'h00, 8'h00, 8'h00, 8'h06,
      8'h07, 8'h01, 8'h00, 8'h02, 8'h00, 8'h08});
    client.idle();
    wait_n(12, 1'b0);
    check_req('{8'h09, 8'h03, 8'h00, 8'h04, 8'h00, 8'h01,
      8'h07, 8'h01, 8'h00, 8'h02, 8'h00, 8'h08}, 6);
    check1(err_q[11], 1'b0);
    err_q.delete();
  endtask
  task automatic t_tcp_rsp();
    client.stall_every = 3;
    rsp_send('{8'h07, 8'h01, 8'h01, 8'h49});
    wait_n(10, 1'b1);
    check_tx('{8'h03, 8'h29, 8'h00, 8'h00, 8'h00, 8'h04,
      8'h07, 8'h01, 8'h01, 8'h49});
    client.stall_every = 0;
  endtask
  task automatic t_refuse();
    rx_port <= 16'h01F7;
    client.send('{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'h09, 8'h03});
    rx_port <= MBFR_TCP_PORT;
    client.send('{8'h01, 8'h02, 8'h00, 8'h01, 8'h00, 8'h02, 8'h09, 8'h03});
    client.send('{8'h01, 8'h02, 8'h00, 8'h00, 8'h01, 8'h02, 8'h09, 8'h03});
    client.send('{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'h55, 8'hAA});
    client.idle();
    wait_n(2, 1'b0);
    check_req('{8'h55, 8'hAA}, 2);
    err_q.delete();
  endtask
  task automatic t_serial();
    mbfr_bytes_t body;
    mbfr_bytes_t rsp;
    logic [15:0] c;
    tcp_mode <= 1'b0;
    @(posedge clk);
    body = '{8'h01, 8'h05, 8'h00, 8'h06, 8'hFF, 8'h00};
    c = crc16(body);
    client.send({body, c[7:0], c[15:8]});
    client.send({body, c[7:0], ~c[15:8]});
    client.idle();
    wait_n(12, 1'b0);
    check_req({body, body}, 6);
    check1(err_q[5], 1'b0);
    check1(err_q[11], 1'b1);
    err_q.delete();
    client.send('{8'h01, 8'h02});
    client.idle();
    wait_n(1, 1'b0);
    check8(8'(req_q.size()), 8'h01);
    check1(lst_q[0], 1'b1);
    check1(err_q[0], 1'b1);
    req_q.delete();
    lst_q.delete();
    err_q.delete();
    rsp = '{8'h01, 8'h01, 8'h02, 8'h00, 8'h12};
    c = crc16(rsp);
    client.stall_every = 2;
    rsp_send(rsp);
    wait_n(7, 1'b1);
    check_tx({rsp, c[7:0], c[15:8]});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_tcp_req();
    t_tcp_rsp();
    t_refuse();
    t_serial();
    tally_and_finish();
  end
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule
